// *** hdl/biosensor_interrupt_flags.sv ***
// Event flags, enables, proximity sequencing and combined interrupt.
//
// Function
// - Set nearly-full flag, status one bit 7, when next sample passes threshold.
// - Status one read clears nearly-full; data read clears it only if option set.
// - In measurement mode set optical-ready, status one bit 6, per new sample.
// - Optical-ready clears on status one read or on FIFO data read.
// - Ambient overflow sets status one bit 5; status one read or soft reset clears.
// - Proximity enable zero skips proximity mode, measurement starts at once.
// - In proximity mode threshold crossing sets status one bit 4; read clears.
// - Proximity mode drives IR emitter with pilot amplitude, not normal amplitude.
// - IR count above threshold sets proximity flag and enters measurement mode.
// - Undervoltage sets status one bit 0, read clears; soft reset never sets it.
// - Supply out-of-range sets status two bit 7; status two read clears.
// - Supply fault reports after 10 ms and keeps re-setting while it lasts.
// - Each finished cardio conversion sets status two bit 2.
// - Enable one bits 7..4 are read-write enables, reset zero, one enables.
// - Repeat type zero re-sets nearly-full every sample; one sets once per condition.
// - Enable two holds supply enable bit 7 and cardio enable bit 2, reset zero.
`timescale 1ns/1ps
module biosensor_interrupt_flags
	import bioflag_pkg::*;
#(
	parameter int SUPPLY_DELAY = SUPPLY_DELAY_CYCLES,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int OCC_W = 6
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] fifo_data_i,
	input wire logic sample_push_i,
	input wire logic [OCC_W-1:0] fifo_occupancy_i,
	input wire logic ambient_limit_i,
	input wire logic optical_config_i,
	input wire logic ir_sample_i,
	input wire logic [7:0] ir_count_i,
	input wire logic battery_undervoltage_i,
	input wire logic analog_supply_out_of_range_i,
	input wire logic cardio_done_i,
	output logic irq_o,
	output logic proximity_mode_o,
	output logic measure_mode_o,
	output logic [7:0] emitter_amplitude_o,
	output logic soft_reset_o
);
	generate
		if (DEPTH < 2 || DEPTH >= (2 ** OCC_W) || DEPTH <= (2 ** FIELD_AFULL_W) - 1) begin : g_check
			$error("biosensor_interrupt_flags: DEPTH does not fit occupancy width");
		end
	endgenerate

	logic rst_meta_reg;
	logic rst_sync_reg;
	wire logic rst_n;

	// Async assert, sync release
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	logic [FLAG_COUNT-1:0] flag_reg;
	logic [FLAG_COUNT-1:0] flag_next;
	logic [FLAG_COUNT-1:0] flag_set;
	logic [FLAG_COUNT-1:0] flag_clr;
	logic [FLAG_COUNT-1:0] enable_reg;
	logic [7:0] fifo_config_reg;
	logic [7:0] prox_thresh_reg;
	logic [7:0] ir_amplitude_reg;
	logic [7:0] pilot_amplitude_reg;
	logic nearly_full_prev_reg;
	optical_mode_t mode_reg;
	optical_mode_t mode_next;

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction : addr_hit

	wire logic rd_status_one = reg_rd_i && addr_hit(reg_addr_i, ADDR_STATUS_ONE);
	wire logic rd_status_two = reg_rd_i && addr_hit(reg_addr_i, ADDR_STATUS_TWO);
	wire logic rd_fifo_data = reg_rd_i && addr_hit(reg_addr_i, ADDR_FIFO_DATA);
	wire logic wr_enable_one = reg_wr_i && addr_hit(reg_addr_i, ADDR_ENABLE_ONE);
	wire logic wr_enable_two = reg_wr_i && addr_hit(reg_addr_i, ADDR_ENABLE_TWO);
	wire logic wr_fifo_config = reg_wr_i && addr_hit(reg_addr_i, ADDR_FIFO_CONFIG);
	wire logic wr_prox_thresh = reg_wr_i && addr_hit(reg_addr_i, ADDR_PROX_THRESH);
	wire logic wr_ir_amplitude = reg_wr_i && addr_hit(reg_addr_i, ADDR_IR_AMPLITUDE);
	wire logic wr_pilot = reg_wr_i && addr_hit(reg_addr_i, ADDR_PILOT_AMPLITUDE);
	wire logic soft_reset = reg_wr_i && addr_hit(reg_addr_i, ADDR_SYS_CONTROL)
		&& reg_wdata_i[BIT_SOFT_RESET];

	// Status register views
	wire logic [7:0] status_one = {flag_reg[F_NEARLY_FULL], flag_reg[F_OPTICAL],
		flag_reg[F_AMBIENT], flag_reg[F_PROXIMITY], 3'h0, flag_reg[F_BATTERY]};
	wire logic [7:0] status_two = {flag_reg[F_SUPPLY], 4'h0, flag_reg[F_CARDIO], 2'h0};
	wire logic [7:0] enable_one = {enable_reg[F_NEARLY_FULL], enable_reg[F_OPTICAL],
		enable_reg[F_AMBIENT], enable_reg[F_PROXIMITY], 4'h0};
	wire logic [7:0] enable_two = {enable_reg[F_SUPPLY], 4'h0, enable_reg[F_CARDIO], 2'h0};

	// Nearly-full condition: free space at or below the programmed value
	wire logic [OCC_W-1:0] afull_level = OCC_W'(DEPTH)
		- OCC_W'(fifo_config_reg[FIELD_AFULL_LSB +: FIELD_AFULL_W]);
	wire logic nearly_full_cond = fifo_occupancy_i >= afull_level;
	wire logic nearly_full_hit = sample_push_i && nearly_full_cond;
	wire logic nearly_full_set = nearly_full_hit
		&& (!fifo_config_reg[BIT_ONCE_TYPE] || !nearly_full_prev_reg);

	wire logic proximity_hit = (mode_reg == MODE_PROXIMITY) && ir_sample_i
		&& (ir_count_i > prox_thresh_reg);
	wire logic supply_event;
	localparam int SUPPLY_CNT_W = $clog2(SUPPLY_DELAY + 1);

	supply_range_timer #(
		.DELAY_CYCLES(SUPPLY_DELAY),
		.CNT_W(SUPPLY_CNT_W)
	) u_supply_timer (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.out_of_range_i(analog_supply_out_of_range_i),
		.event_o(supply_event)
	);

	assign flag_set[F_NEARLY_FULL] = nearly_full_set;
	assign flag_set[F_OPTICAL] = sample_push_i && (mode_reg == MODE_MEASURE);
	assign flag_set[F_AMBIENT] = ambient_limit_i;
	assign flag_set[F_PROXIMITY] = proximity_hit;
	assign flag_set[F_BATTERY] = battery_undervoltage_i;
	assign flag_set[F_SUPPLY] = supply_event;
	assign flag_set[F_CARDIO] = cardio_done_i;

	assign flag_clr[F_NEARLY_FULL] = rd_status_one || soft_reset
		|| (rd_fifo_data && fifo_config_reg[BIT_CLEAR_ON_DATA]);
	assign flag_clr[F_OPTICAL] = rd_status_one || rd_fifo_data || soft_reset;
	assign flag_clr[F_AMBIENT] = rd_status_one || soft_reset;
	assign flag_clr[F_PROXIMITY] = rd_status_one || soft_reset;
	// Soft reset deliberately leaves the battery flag alone
	assign flag_clr[F_BATTERY] = rd_status_one;
	assign flag_clr[F_SUPPLY] = rd_status_two || soft_reset;
	assign flag_clr[F_CARDIO] = rd_status_two || soft_reset;

	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set || (cur && !clr);
	endfunction : sticky

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
			assign flag_next[gi] = sticky(flag_reg[gi], flag_set[gi], flag_clr[gi]);
		end
	endgenerate

	// Proximity stage only when its interrupt is enabled
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_IDLE: begin
				if (optical_config_i) begin
					mode_next = enable_reg[F_PROXIMITY] ? MODE_PROXIMITY : MODE_MEASURE;
				end
			end
			MODE_PROXIMITY: begin
				if (!optical_config_i) begin
					mode_next = MODE_IDLE;
				end else if (!enable_reg[F_PROXIMITY]) begin
					mode_next = MODE_MEASURE;
				end else if (proximity_hit) begin
					mode_next = MODE_MEASURE;
				end
			end
			MODE_MEASURE: begin
				if (!optical_config_i) begin
					mode_next = MODE_IDLE;
				end
			end
			default: mode_next = MODE_IDLE;
		endcase
	end

	wire logic [7:0] read_mux = addr_hit(reg_addr_i, ADDR_STATUS_ONE) ? status_one :
		addr_hit(reg_addr_i, ADDR_STATUS_TWO) ? status_two :
		addr_hit(reg_addr_i, ADDR_ENABLE_ONE) ? enable_one :
		addr_hit(reg_addr_i, ADDR_ENABLE_TWO) ? enable_two :
		addr_hit(reg_addr_i, ADDR_FIFO_DATA) ? fifo_data_i :
		addr_hit(reg_addr_i, ADDR_FIFO_CONFIG) ? fifo_config_reg :
		addr_hit(reg_addr_i, ADDR_PROX_THRESH) ? prox_thresh_reg :
		addr_hit(reg_addr_i, ADDR_IR_AMPLITUDE) ? ir_amplitude_reg :
		addr_hit(reg_addr_i, ADDR_PILOT_AMPLITUDE) ? pilot_amplitude_reg : RST_ZERO;

	wire logic any_pending = |(flag_reg & enable_reg);
	wire logic [7:0] amplitude_sel = (mode_next == MODE_PROXIMITY) ? pilot_amplitude_reg
		: ir_amplitude_reg;

	// Flags: the read data captures the old value on the edge the clear lands
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= '0;
			fifo_config_reg <= RST_FIFO_CONFIG;
			prox_thresh_reg <= RST_ZERO;
			ir_amplitude_reg <= RST_ZERO;
			pilot_amplitude_reg <= RST_ZERO;
		end else if (soft_reset) begin
			enable_reg <= '0;
			fifo_config_reg <= RST_FIFO_CONFIG;
			prox_thresh_reg <= RST_ZERO;
			ir_amplitude_reg <= RST_ZERO;
			pilot_amplitude_reg <= RST_ZERO;
		end else begin
			if (wr_enable_one) begin
				enable_reg[F_NEARLY_FULL] <= reg_wdata_i[BIT_NEARLY_FULL];
				enable_reg[F_OPTICAL] <= reg_wdata_i[BIT_OPTICAL];
				enable_reg[F_AMBIENT] <= reg_wdata_i[BIT_AMBIENT];
				enable_reg[F_PROXIMITY] <= reg_wdata_i[BIT_PROXIMITY];
			end
			if (wr_enable_two) begin
				enable_reg[F_SUPPLY] <= reg_wdata_i[BIT_SUPPLY];
				enable_reg[F_CARDIO] <= reg_wdata_i[BIT_CARDIO];
			end
			if (wr_fifo_config) begin
				fifo_config_reg <= reg_wdata_i & 8'h7f;
			end
			if (wr_prox_thresh) begin
				prox_thresh_reg <= reg_wdata_i;
			end
			if (wr_ir_amplitude) begin
				ir_amplitude_reg <= reg_wdata_i;
			end
			if (wr_pilot) begin
				pilot_amplitude_reg <= reg_wdata_i;
			end
		end
	end

	// Battery flag enable has no register; it never reaches the interrupt line
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			nearly_full_prev_reg <= 1'b0;
			mode_reg <= MODE_IDLE;
			reg_rdata_o <= RST_ZERO;
			irq_o <= 1'b0;
			proximity_mode_o <= 1'b0;
			measure_mode_o <= 1'b0;
			emitter_amplitude_o <= RST_ZERO;
			soft_reset_o <= 1'b0;
		end else begin
			if (sample_push_i) begin
				nearly_full_prev_reg <= nearly_full_cond;
			end
			mode_reg <= soft_reset ? MODE_IDLE : mode_next;
			if (reg_rd_i) begin
				reg_rdata_o <= read_mux;
			end
			irq_o <= any_pending;
			proximity_mode_o <= (mode_next == MODE_PROXIMITY) && !soft_reset;
			measure_mode_o <= (mode_next == MODE_MEASURE) && !soft_reset;
			emitter_amplitude_o <= amplitude_sel;
			soft_reset_o <= soft_reset;
		end
	end
endmodule : biosensor_interrupt_flags

// *** hdl/bioflag_pkg.sv ***
// Constants shared by the bio-sensor event flag block.
package bioflag_pkg;
	// Register offsets on the register port
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h00;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h01;
	localparam logic [7:0] ADDR_ENABLE_ONE = 8'h02;
	localparam logic [7:0] ADDR_ENABLE_TWO = 8'h03;
	localparam logic [7:0] ADDR_FIFO_DATA = 8'h07;
	localparam logic [7:0] ADDR_FIFO_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_SYS_CONTROL = 8'h0d;
	localparam logic [7:0] ADDR_PROX_THRESH = 8'h10;
	localparam logic [7:0] ADDR_IR_AMPLITUDE = 8'h11;
	localparam logic [7:0] ADDR_PILOT_AMPLITUDE = 8'h15;

	// Bit positions in the status and enable registers
	localparam int BIT_NEARLY_FULL = 7;
	localparam int BIT_OPTICAL = 6;
	localparam int BIT_AMBIENT = 5;
	localparam int BIT_PROXIMITY = 4;
	localparam int BIT_BATTERY = 0;
	localparam int BIT_SUPPLY = 7;
	localparam int BIT_CARDIO = 2;

	// FIFO configuration fields and the system control soft reset bit
	localparam int BIT_CLEAR_ON_DATA = 6;
	localparam int BIT_ONCE_TYPE = 5;
	localparam int BIT_ROLLS = 4;
	localparam int FIELD_AFULL_LSB = 0;
	localparam int FIELD_AFULL_W = 4;
	localparam int BIT_SOFT_RESET = 0;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_FIFO_CONFIG = 8'h0f;

	// Flag vector indices
	localparam int FLAG_COUNT = 7;
	localparam int F_NEARLY_FULL = 0;
	localparam int F_OPTICAL = 1;
	localparam int F_AMBIENT = 2;
	localparam int F_PROXIMITY = 3;
	localparam int F_BATTERY = 4;
	localparam int F_SUPPLY = 5;
	localparam int F_CARDIO = 6;

	// Timing
	localparam int CLOCK_HZ = 125000000;
	localparam int SUPPLY_DELAY_MS = 10;
	localparam int SUPPLY_DELAY_CYCLES = CLOCK_HZ / 1000 * SUPPLY_DELAY_MS;

	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_PROXIMITY = 2'b01,
		MODE_MEASURE = 2'b11
	} optical_mode_t;
endpackage : bioflag_pkg

// *** hdl/supply_range_timer.sv ***
// Persistence timer that turns an out-of-range level into periodic events.
`timescale 1ns/1ps
module supply_range_timer #(
	parameter int DELAY_CYCLES = 1250000,
	parameter int CNT_W = 21
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic out_of_range_i,
	output logic event_o
);
	logic [CNT_W-1:0] count_reg;
	wire logic count_done;

	generate
		// The width bound keeps the power of two below inside a 32-bit int
		if (CNT_W < 1 || CNT_W > 30 || DELAY_CYCLES < 1 || DELAY_CYCLES > (2 ** CNT_W)) begin : g_check
			$error("supply_range_timer: DELAY_CYCLES does not fit the counter");
		end
	endgenerate

	assign count_done = (count_reg == CNT_W'(DELAY_CYCLES - 1));

	// Restarts after each report so the flag keeps coming back while the fault lasts
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= '0;
			event_o <= 1'b0;
		end else begin
			event_o <= out_of_range_i && count_done;
			if (!out_of_range_i || count_done) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + CNT_W'(1);
			end
		end
	end
endmodule : supply_range_timer

// *** sim/bioflag_monitor.sv ***
// Port-level assertions for the bio-sensor event flag block.
`timescale 1ns/1ps
module bioflag_monitor (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic ambient_limit_i,
	input wire logic optical_config_i,
	input wire logic ir_sample_i,
	input wire logic [7:0] ir_count_i,
	input wire logic cardio_done_i,
	input wire logic irq_o,
	input wire logic proximity_mode_o,
	input wire logic measure_mode_o,
	input wire logic [7:0] emitter_amplitude_o,
	input wire logic soft_reset_o
);
	logic [7:0] e1_reg, e2_reg, thr_reg, pilot_reg;
	wire soft_wr = reg_wr_i && reg_addr_i == 8'h0d && reg_wdata_i[0];
	// Shadow copies of the enables, proximity threshold and pilot amplitude the assertions depend on
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			e1_reg <= 8'h00;
			e2_reg <= 8'h00;
			thr_reg <= 8'h00;
			pilot_reg <= 8'h00;
		end else if (soft_wr) begin
			e1_reg <= 8'h00;
			e2_reg <= 8'h00;
			thr_reg <= 8'h00;
			pilot_reg <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 8'h02) e1_reg <= reg_wdata_i & 8'hf0;
			if (reg_addr_i == 8'h03) e2_reg <= reg_wdata_i & 8'h84;
			if (reg_addr_i == 8'h10) thr_reg <= reg_wdata_i;
			if (reg_addr_i == 8'h15) pilot_reg <= reg_wdata_i;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	a_mode_exclusive: assert property (!(proximity_mode_o && measure_mode_o))
		else $error("both optical modes active");
	a_prox_exit: assert property (proximity_mode_o && optical_config_i && ir_sample_i
		&& ir_count_i > thr_reg |-> ##[1:2] measure_mode_o)
		else $error("no measurement after threshold crossing");
	a_pilot_drive: assert property (proximity_mode_o && $past(proximity_mode_o)
		&& !$past(reg_wr_i) |-> emitter_amplitude_o == pilot_reg)
		else $error("emitter not at pilot amplitude");
	a_soft_pulse: assert property (soft_wr |=> soft_reset_o ##1 !soft_reset_o)
		else $error("soft reset pulse wrong");
	a_status_two_spare: assert property (reg_rd_i && reg_addr_i == 8'h01
		|=> (reg_rdata_o & 8'h7b) == 8'h00)
		else $error("unused status two bits set");
	a_irq_masked: assert property (e1_reg == 8'h00 && e2_reg == 8'h00
		&& $past(e1_reg) == 8'h00 && $past(e2_reg) == 8'h00 |-> !irq_o)
		else $error("interrupt with all enables off");
	a_cardio_irq: assert property (e2_reg[2] && cardio_done_i |-> ##2 irq_o)
		else $error("cardio event gave no interrupt");
	a_ambient_irq: assert property (e1_reg[5] && ambient_limit_i |-> ##2 irq_o)
		else $error("ambient event gave no interrupt");
	a_skip_prox: assert property (optical_config_i && !e1_reg[4] && !proximity_mode_o
		&& !measure_mode_o |-> ##[1:3] measure_mode_o)
		else $error("measurement did not start");
endmodule : bioflag_monitor

bind biosensor_interrupt_flags bioflag_monitor mon (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
	.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .ambient_limit_i, .optical_config_i, .ir_sample_i,
	.ir_count_i, .cardio_done_i, .irq_o, .proximity_mode_o, .measure_mode_o,
	.emitter_amplitude_o, .soft_reset_o);

// *** sim/reg_host_model.sv ***
// Host side of the register port: single byte reads and writes.
`timescale 1ns/1ps
module reg_host_model (
	input wire logic clock_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_wdata_o
);
	initial begin
		reg_addr_o = 8'h5a;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'ha5;
	end
	// One strobe cycle per byte; never both strobes at once
	task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
		@(negedge clock_i);
		reg_addr_o = addr;
		reg_wdata_o = data;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		@(negedge clock_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		// Idle bus shows no stale address or data
		reg_addr_o = ~addr;
		reg_wdata_o = ~data;
	endtask : access
endmodule : reg_host_model

// *** sim/test_biosensor_interrupt_flags.sv ***
// Self-checking bench for the event flag block.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module test_biosensor_interrupt_flags;
	import bioflag_pkg::*;
	logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, sample_push_i, ambient_limit_i, optical_config_i;
	logic ir_sample_i, battery_undervoltage_i, analog_supply_out_of_range_i, cardio_done_i;
	logic irq_o, proximity_mode_o, measure_mode_o, soft_reset_o, rd_seen;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fifo_data_i, ir_count_i;
	logic [7:0] emitter_amplitude_o, exp_v;
	logic [5:0] fifo_occupancy_i;
	logic [31:0] seed = 32'h6590e3d8;
	logic [31:0] r;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int samples_checked = 0;
	biosensor_interrupt_flags #(.SUPPLY_DELAY(20)) dut (.clock_i, .rst_n_i, .reg_addr_i,
		.reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .fifo_data_i, .sample_push_i,
		.fifo_occupancy_i, .ambient_limit_i, .optical_config_i, .ir_sample_i, .ir_count_i,
		.battery_undervoltage_i, .analog_supply_out_of_range_i, .cardio_done_i, .irq_o,
		.proximity_mode_o, .measure_mode_o, .emitter_amplitude_o, .soft_reset_o);
	reg_host_model host (.clock_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
	function logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(a, 8'h00, 1'b0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(a, d, 1'b1);
	endtask : wr
	task automatic rd_data();
		r = next_rand();
		fifo_data_i = r[7:0];
		rd(ADDR_FIFO_DATA, r[7:0]);
	endtask : rd_data
	task automatic pulse(ref logic s);
		@(negedge clock_i);
		s = 1'b1;
		@(negedge clock_i);
		s = 1'b0;
	endtask : pulse
	task automatic push(input logic [5:0] n);
		fifo_occupancy_i = n;
		pulse(sample_push_i);
	endtask : push
	task automatic ir(input logic [7:0] c);
		ir_count_i = c;
		pulse(ir_sample_i);
		repeat (2) @(negedge clock_i);
	endtask : ir
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// Read data is judged one cycle after the read strobe, oldest note first
	always @(posedge clock_i) rd_seen <= reg_rd_i;
	always @(negedge clock_i) begin
		if (rd_seen && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK("read data", exp_v, reg_rdata_o)
		end
	end
	initial begin
		#(8 * 20000);
		num_errors++;
		complete_run();
	end
	initial begin
		{rst_n_i, sample_push_i, ambient_limit_i, optical_config_i, ir_sample_i} = '0;
		{battery_undervoltage_i, analog_supply_out_of_range_i, cardio_done_i} = '0;
		{fifo_data_i, ir_count_i, fifo_occupancy_i} = '0;
		repeat (20) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		for (int i = 0; i < 4; i++) rd(8'(i), 8'h00);
		wr(ADDR_STATUS_ONE, 8'hff);
		rd(ADDR_STATUS_ONE, 8'h00);
		rd(8'h20, 8'h00);
		$display("test reset_values done");
		pulse(battery_undervoltage_i);
		rd(ADDR_STATUS_ONE, 8'h01);
		rd(ADDR_STATUS_ONE, 8'h00);
		wr(ADDR_SYS_CONTROL, 8'h01);
		repeat (3) @(negedge clock_i);
		rd(ADDR_STATUS_ONE, 8'h00);
		// A pending undervoltage flag must survive a soft reset
		pulse(battery_undervoltage_i);
		wr(ADDR_SYS_CONTROL, 8'h01);
		repeat (3) @(negedge clock_i);
		rd(ADDR_STATUS_ONE, 8'h01);
		fork
			pulse(ambient_limit_i);
			rd(ADDR_STATUS_ONE, 8'h00);
		join
		rd(ADDR_STATUS_ONE, 8'h20);
		$display("test battery_soft_reset done");
		r = next_rand();
		wr(ADDR_ENABLE_ONE, r[7:0]);
		rd(ADDR_ENABLE_ONE, r[7:0] & 8'hf0);
		wr(ADDR_ENABLE_TWO, r[15:8]);
		rd(ADDR_ENABLE_TWO, r[15:8] & 8'h84);
		wr(ADDR_ENABLE_ONE, 8'h20);
		wr(ADDR_ENABLE_TWO, 8'h04);
		pulse(ambient_limit_i);
		rd_data();
		rd(ADDR_STATUS_ONE, 8'h20);
		rd(ADDR_STATUS_ONE, 8'h00);
		pulse(cardio_done_i);
		@(negedge clock_i);
		`CHK("irq", 1'b1, irq_o)
		rd(ADDR_STATUS_TWO, 8'h04);
		rd(ADDR_STATUS_TWO, 8'h00);
		repeat (2) @(negedge clock_i);
		`CHK("irq", 1'b0, irq_o)
		$display("test events_irq done");
		analog_supply_out_of_range_i = 1'b1;
		repeat (8) @(negedge clock_i);
		rd(ADDR_STATUS_TWO, 8'h00);
		repeat (14) @(negedge clock_i);
		rd(ADDR_STATUS_TWO, 8'h80);
		repeat (18) @(negedge clock_i);
		rd(ADDR_STATUS_TWO, 8'h80);
		analog_supply_out_of_range_i = 1'b0;
		repeat (30) @(negedge clock_i);
		rd(ADDR_STATUS_TWO, 8'h00);
		$display("test supply done");
		wr(ADDR_FIFO_CONFIG, 8'h04);
		push(6'd27);
		rd(ADDR_STATUS_ONE, 8'h00);
		push(6'd28);
		rd(ADDR_STATUS_ONE, 8'h80);
		push(6'd29);
		rd_data();
		rd(ADDR_STATUS_ONE, 8'h80);
		wr(ADDR_FIFO_CONFIG, 8'h24);
		push(6'd30);
		rd(ADDR_STATUS_ONE, 8'h00);
		wr(ADDR_FIFO_CONFIG, 8'h44);
		push(6'd28);
		rd_data();
		rd(ADDR_STATUS_ONE, 8'h00);
		$display("test nearly_full done");
		wr(ADDR_PROX_THRESH, 8'h40);
		wr(ADDR_PILOT_AMPLITUDE, 8'h33);
		wr(ADDR_IR_AMPLITUDE, 8'h99);
		wr(ADDR_ENABLE_ONE, 8'h10);
		optical_config_i = 1'b1;
		repeat (4) @(negedge clock_i);
		`CHK("emitter", 8'h33, emitter_amplitude_o)
		ir(8'h40);
		`CHK("proximity mode", 1'b1, proximity_mode_o)
		ir(8'h41);
		`CHK("measure mode", 1'b1, measure_mode_o)
		rd(ADDR_STATUS_ONE, 8'h10);
		`CHK("emitter", 8'h99, emitter_amplitude_o)
		push(6'd1);
		rd(ADDR_STATUS_ONE, 8'h40);
		push(6'd2);
		rd_data();
		rd(ADDR_STATUS_ONE, 8'h00);
		optical_config_i = 1'b0;
		wr(ADDR_ENABLE_ONE, 8'h00);
		repeat (3) @(negedge clock_i);
		optical_config_i = 1'b1;
		repeat (5) @(negedge clock_i);
		`CHK("skip proximity", 2'b01, {proximity_mode_o, measure_mode_o})
		optical_config_i = 1'b0;
		$display("test proximity done");
		repeat (4) @(negedge clock_i);
		complete_run();
	end
endmodule : test_biosensor_interrupt_flags
